//--- hdl/dprcs_pkg.sv
// Purpose: shared constants and types of the dual-port buffer RAM cycle stealer
// Assumes: 125 MHz system clock, 8 MHz expansion bus clock sampled as a pin
// Notes: register offsets are byte addresses on a 32-bit APB slave
`default_nettype none
package dprcs_pkg;
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [APB_AW-1:0] STEAL_CNT_OFFSET = 12'h008;

  // control word layout, shared by the APB word and the host data byte
  localparam int PAGE_LSB = 0;
  localparam int PAGE_W = 4;
  localparam int CTRL_RESET_POS = 4;
  localparam int LOOPBACK_POS = 5;
  localparam int IRQ_CLEAR_POS = 6;
  localparam int CHAN_ATTN_POS = 7;

  // status word layout
  localparam int ST_STATE_LSB = 0;
  localparam int ST_IRQ_POS = 2;
  localparam int ST_SELECT_POS = 3;
  localparam int ST_HOLD_POS = 4;

  localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;
  localparam logic CTRL_RESET_RESET = 1'b1;
  localparam logic LOOPBACK_RESET = 1'b0;
  localparam logic CHAN_ATTN_RESET = 1'b0;
  localparam logic [15:0] STEAL_CNT_RESET = 16'h0000;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    DPRCS_IDLE,
    DPRCS_SETUP,
    DPRCS_ACCESS,
    DPRCS_RELEASE
  } dprcs_state_t;

  // host cycle target, decoded outside from the card address
  typedef enum logic [1:0] {
    DPRCS_TGT_RAM,
    DPRCS_TGT_PROM,
    DPRCS_TGT_REGS,
    DPRCS_TGT_NONE
  } dprcs_target_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } dprcs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dprcs_apb_rsp_t;

  // host expansion bus pins, all asynchronous to clk
  typedef struct packed {
    logic bus_clock;
    logic podule_select;
    logic read_not_write;
    dprcs_target_t target;
    logic [7:0] wdata;
  } dprcs_host_pins_t;

  typedef struct packed {
    logic host_bufs_enable;
    logic ctrl_bufs_enable;
    logic buffer_write_strobe_n;
    logic ram_output_enable;
    logic id_prom_output_enable;
    logic ctrl_ready;
  } dprcs_ram_ctl_t;
endpackage
`default_nettype wire

//--- hdl/dprcs_pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: output follows only when stages two and three agree
`default_nettype none
module dprcs_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } dprcs_sync_t;

  dprcs_sync_t state_reg;
  dprcs_sync_t state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.s1 = pin;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    // per bit: a change counts once the later two stages agree
    for (int i = 0; i < WIDTH; i++)
    begin
      if (state_reg.s2[i] == state_reg.s3[i])
      begin
        state_next.out[i] = state_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= '{s1: RESET_VALUE, s2: RESET_VALUE, s3: RESET_VALUE, out: RESET_VALUE};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.out;
endmodule
`default_nettype wire

//--- hdl/dprcs_irq_latch.sv
// Purpose: turns the controller's edge-style interrupt into a held level
// Assumes: irq and clear are synchronous to clk
// Notes: a set in the clear cycle wins; re-arming waits for irq to drop
`default_nettype none
module dprcs_irq_latch (
  input wire logic clk,
  input wire logic srst,
  input wire logic irq,
  input wire logic set_window,
  input wire logic clear,
  output logic latched
);
  typedef struct packed {
    logic held;
    logic armed;
  } dprcs_latch_t;

  dprcs_latch_t state_reg;
  dprcs_latch_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (clear)
    begin
      state_next.held = 1'b0;
      state_next.armed = 1'b0;
    end
    // an interrupt still standing at clear must drop before it may latch again
    if (!irq)
    begin
      state_next.armed = 1'b1;
    end
    if (irq && state_reg.armed && set_window)
    begin
      state_next.held = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= '{held: 1'b0, armed: 1'b1};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign latched = state_reg.held;
endmodule
`default_nettype wire

//--- hdl/dprcs_cycle_stealer.sv
// Purpose: cycle-stealing arbiter between host and network controller on a shared buffer RAM
// Assumes: host bus, hard reset, bus request and interrupt pins asynchronous to clk, APB synchronous; expansion bus clock below clk/4
// Notes: state advances on filtered falling edges of the expansion bus clock
`default_nettype none
module dprcs_cycle_stealer #(
  parameter int STEAL_CNT_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hard_reset_n,
  input wire dprcs_pkg::dprcs_host_pins_t host_pins,
  input wire logic ctrl_bus_request,
  input wire logic ctrl_irq,
  input wire dprcs_pkg::dprcs_apb_req_t apb_req,
  output dprcs_pkg::dprcs_apb_rsp_t apb_rsp,
  output dprcs_pkg::dprcs_ram_ctl_t ram_ctl,
  output logic [dprcs_pkg::PAGE_W-1:0] page_select,
  output logic controller_reset_bit,
  output logic loopback_bit,
  output logic chan_attn_bit,
  output logic bus_grab_grant,
  output logic card_level_irq
);
  localparam int PIN_W = $bits(dprcs_pkg::dprcs_host_pins_t) + 3;

  typedef struct packed {
    dprcs_pkg::dprcs_state_t st;
    logic served;
    logic bus_clock_prev;
    logic [dprcs_pkg::PAGE_W-1:0] page;
    logic ctrl_reset;
    logic loopback;
    logic irq_clear;
    logic chan_attn;
    logic [STEAL_CNT_W-1:0] steal_cnt;
    dprcs_pkg::dprcs_ram_ctl_t ram;
    logic grant;
    logic irq_out;
    dprcs_pkg::dprcs_apb_rsp_t rsp;
  } dprcs_core_t;

  dprcs_core_t state_reg;
  dprcs_core_t state_next;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_level;
  dprcs_pkg::dprcs_host_pins_t host;
  logic hard_reset_n_s;
  logic bus_request_s;
  logic irq_s;
  logic irq_latched;
  logic bus_fall;
  logic apb_access;
  logic apb_write;
  logic apb_known;
  logic host_reg_write;

  assign pins_raw = {host_pins, hard_reset_n, ctrl_bus_request, ctrl_irq};

  // one synchroniser for every asynchronous pin keeps their delays equal
  dprcs_pin_sync #(
    .WIDTH(PIN_W),
    .RESET_VALUE({{(PIN_W - 3){1'b0}}, 3'b100})
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .pin(pins_raw),
    .level(pins_level)
  );

  assign host = pins_level[PIN_W-1:3];
  assign hard_reset_n_s = pins_level[2];
  assign bus_request_s = pins_level[1];
  assign irq_s = pins_level[0];

  assign bus_fall = state_reg.bus_clock_prev && !host.bus_clock;

  assign apb_access = apb_req.psel && apb_req.penable && state_reg.rsp.pready;
  assign apb_write = apb_access && apb_req.pwrite;
  assign apb_known = (apb_req.paddr == dprcs_pkg::CTRL_OFFSET)
                  || (apb_req.paddr == dprcs_pkg::STATUS_OFFSET)
                  || (apb_req.paddr == dprcs_pkg::STEAL_CNT_OFFSET);

  assign host_reg_write = bus_fall && (state_reg.st == dprcs_pkg::DPRCS_ACCESS)
                       && (host.target == dprcs_pkg::DPRCS_TGT_REGS) && !host.read_not_write;

  dprcs_irq_latch u_irq_latch (
    .clk(clk),
    .srst(srst),
    .irq(irq_s),
    .set_window(state_reg.st == dprcs_pkg::DPRCS_IDLE),
    .clear(state_reg.irq_clear),
    .latched(irq_latched)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.bus_clock_prev = host.bus_clock;
    // interrupt clear acts for one cycle only
    state_next.irq_clear = 1'b0;
    state_next.grant = bus_request_s;
    state_next.irq_out = irq_latched;

    if (!host.podule_select)
    begin
      state_next.served = 1'b0;
    end

    if (bus_fall)
    begin
      case (state_reg.st)
        dprcs_pkg::DPRCS_IDLE:
        begin
          if (host.podule_select && !state_reg.served)
          begin
            state_next.st = dprcs_pkg::DPRCS_SETUP;
            state_next.served = 1'b1;
          end
        end
        dprcs_pkg::DPRCS_SETUP:
        begin
          state_next.st = dprcs_pkg::DPRCS_ACCESS;
        end
        dprcs_pkg::DPRCS_ACCESS:
        begin
          state_next.st = dprcs_pkg::DPRCS_RELEASE;
          state_next.steal_cnt = state_reg.steal_cnt + 1'b1;
        end
        dprcs_pkg::DPRCS_RELEASE:
        begin
          state_next.st = dprcs_pkg::DPRCS_IDLE;
        end
        default:
        begin
          state_next.st = dprcs_pkg::DPRCS_IDLE;
        end
      endcase
    end

    if (!hard_reset_n_s)
    begin
      state_next.st = dprcs_pkg::DPRCS_IDLE;
    end

    state_next.ram.host_bufs_enable = (state_next.st == dprcs_pkg::DPRCS_SETUP)
                                   || (state_next.st == dprcs_pkg::DPRCS_ACCESS);
    state_next.ram.ctrl_bufs_enable = !state_next.ram.host_bufs_enable;
    state_next.ram.ctrl_ready = (state_next.st == dprcs_pkg::DPRCS_IDLE);
    state_next.ram.buffer_write_strobe_n = !((state_next.st == dprcs_pkg::DPRCS_ACCESS)
                                          && (host.target == dprcs_pkg::DPRCS_TGT_RAM)
                                          && !host.read_not_write);
    state_next.ram.ram_output_enable = (state_next.st == dprcs_pkg::DPRCS_ACCESS)
                                    && (host.target == dprcs_pkg::DPRCS_TGT_RAM)
                                    && host.read_not_write;
    state_next.ram.id_prom_output_enable = (state_next.st == dprcs_pkg::DPRCS_ACCESS)
                                        && (host.target == dprcs_pkg::DPRCS_TGT_PROM)
                                        && host.read_not_write;

    if (host_reg_write)
    begin
      state_next.page = host.wdata[dprcs_pkg::PAGE_LSB +: dprcs_pkg::PAGE_W];
      state_next.ctrl_reset = host.wdata[dprcs_pkg::CTRL_RESET_POS];
      state_next.loopback = host.wdata[dprcs_pkg::LOOPBACK_POS];
      state_next.irq_clear = host.wdata[dprcs_pkg::IRQ_CLEAR_POS];
      state_next.chan_attn = host.wdata[dprcs_pkg::CHAN_ATTN_POS];
    end
    else if (apb_write && (apb_req.paddr == dprcs_pkg::CTRL_OFFSET))
    begin
      state_next.page = apb_req.pwdata[dprcs_pkg::PAGE_LSB +: dprcs_pkg::PAGE_W];
      state_next.ctrl_reset = apb_req.pwdata[dprcs_pkg::CTRL_RESET_POS];
      state_next.loopback = apb_req.pwdata[dprcs_pkg::LOOPBACK_POS];
      state_next.irq_clear = apb_req.pwdata[dprcs_pkg::IRQ_CLEAR_POS];
      state_next.chan_attn = apb_req.pwdata[dprcs_pkg::CHAN_ATTN_POS];
    end

    // apb: no wait cycle, answer ready in the first access cycle
    state_next.rsp.pready = apb_req.psel && !apb_req.penable && !state_reg.rsp.pready;
    state_next.rsp.pslverr = apb_req.psel && !apb_req.penable && !state_reg.rsp.pready && !apb_known;
    state_next.rsp.prdata = 32'h0000_0000;
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
    begin
      case (apb_req.paddr)
        dprcs_pkg::CTRL_OFFSET:
        begin
          state_next.rsp.prdata[dprcs_pkg::PAGE_LSB +: dprcs_pkg::PAGE_W] = state_reg.page;
          state_next.rsp.prdata[dprcs_pkg::CTRL_RESET_POS] = state_reg.ctrl_reset;
          state_next.rsp.prdata[dprcs_pkg::LOOPBACK_POS] = state_reg.loopback;
          state_next.rsp.prdata[dprcs_pkg::CHAN_ATTN_POS] = state_reg.chan_attn;
        end
        dprcs_pkg::STATUS_OFFSET:
        begin
          state_next.rsp.prdata[dprcs_pkg::ST_STATE_LSB +: 2] = state_reg.st;
          state_next.rsp.prdata[dprcs_pkg::ST_IRQ_POS] = state_reg.irq_out;
          state_next.rsp.prdata[dprcs_pkg::ST_SELECT_POS] = host.podule_select;
          state_next.rsp.prdata[dprcs_pkg::ST_HOLD_POS] = state_reg.grant;
        end
        dprcs_pkg::STEAL_CNT_OFFSET:
        begin
          state_next.rsp.prdata[STEAL_CNT_W-1:0] = state_reg.steal_cnt;
        end
        default:
        begin
          state_next.rsp.prdata = 32'h0000_0000;
        end
      endcase
    end
    else if (state_reg.rsp.pready || apb_req.penable)
    begin
      state_next.rsp.prdata = state_reg.rsp.prdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg.st <= dprcs_pkg::DPRCS_IDLE;
      state_reg.served <= 1'b0;
      state_reg.bus_clock_prev <= 1'b0;
      state_reg.page <= dprcs_pkg::PAGE_RESET;
      state_reg.ctrl_reset <= dprcs_pkg::CTRL_RESET_RESET;
      state_reg.loopback <= dprcs_pkg::LOOPBACK_RESET;
      state_reg.irq_clear <= 1'b0;
      state_reg.chan_attn <= dprcs_pkg::CHAN_ATTN_RESET;
      state_reg.steal_cnt <= STEAL_CNT_W'(dprcs_pkg::STEAL_CNT_RESET);
      state_reg.ram <= '{host_bufs_enable: 1'b0, ctrl_bufs_enable: 1'b1, buffer_write_strobe_n: 1'b1,
                         ram_output_enable: 1'b0, id_prom_output_enable: 1'b0, ctrl_ready: 1'b1};
      state_reg.grant <= 1'b0;
      state_reg.irq_out <= 1'b0;
      state_reg.rsp <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp = state_reg.rsp;
  assign ram_ctl = state_reg.ram;
  assign page_select = state_reg.page;
  assign controller_reset_bit = state_reg.ctrl_reset;
  assign loopback_bit = state_reg.loopback;
  assign chan_attn_bit = state_reg.chan_attn;
  assign bus_grab_grant = state_reg.grant;
  assign card_level_irq = state_reg.irq_out;
endmodule
`default_nettype wire

//--- dv/dprcs_cycle_stealer_properties.sv
// Purpose: port-level checks of the cycle stealer
// Assumes: bus clock period of 16 clk, as the bench makes it
// Notes: checks other than chk_hard_idle pause while hard reset is low, since it may cut a steal short
`default_nettype none
module dprcs_cycle_stealer_properties #(
  parameter int STEAL_CNT_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hard_reset_n,
  input wire dprcs_pkg::dprcs_host_pins_t host_pins,
  input wire logic ctrl_bus_request,
  input wire logic ctrl_irq,
  input wire dprcs_pkg::dprcs_apb_req_t apb_req,
  input wire dprcs_pkg::dprcs_apb_rsp_t apb_rsp,
  input wire dprcs_pkg::dprcs_ram_ctl_t ram_ctl,
  input wire logic [dprcs_pkg::PAGE_W-1:0] page_select,
  input wire logic controller_reset_bit,
  input wire logic loopback_bit,
  input wire logic chan_attn_bit,
  input wire logic bus_grab_grant,
  input wire logic card_level_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // three bus periods of 16 clk
  localparam int LOW_CYCLES = 48;
  logic [7:0] low_cnt_reg;
  logic [7:0] clr_age_reg;
  logic [7:0] irq_hist_reg;
  logic clr_req;
  assign clr_req = (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
    && apb_req.paddr == dprcs_pkg::CTRL_OFFSET && apb_req.pwdata[dprcs_pkg::IRQ_CLEAR_POS])
    || (host_pins.podule_select && !host_pins.read_not_write
    && host_pins.target == dprcs_pkg::DPRCS_TGT_REGS && host_pins.wdata[dprcs_pkg::IRQ_CLEAR_POS]);
  always_ff @(posedge clk)
  begin
    low_cnt_reg <= ram_ctl.ctrl_ready ? 8'h00 : low_cnt_reg + 8'h01;
    clr_age_reg <= (clr_req || srst) ? 8'h00 : clr_age_reg + {7'h00, clr_age_reg != 8'hFF};
    irq_hist_reg <= {irq_hist_reg[6:0], ctrl_irq};
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst || !hard_reset_n);
  chk_bufs_swap: assert property (ram_ctl.host_bufs_enable != ram_ctl.ctrl_bufs_enable)
    else $error("buffer enables not complementary");
  chk_setup_outputs: assert property ($fell(ram_ctl.ctrl_ready) |->
    ram_ctl.host_bufs_enable && ram_ctl.buffer_write_strobe_n) else $error("setup outputs wrong");
  chk_select_steals: assert property ($rose(host_pins.podule_select) && ram_ctl.ctrl_ready && hard_reset_n
    |-> ##[1:32] !ram_ctl.ctrl_ready) else $error("select did not start a steal");
  chk_access_enables: assert property ((!ram_ctl.buffer_write_strobe_n || ram_ctl.ram_output_enable
    || ram_ctl.id_prom_output_enable) |-> ram_ctl.host_bufs_enable && !ram_ctl.ctrl_ready)
    else $error("enable outside access");
  chk_one_enable: assert property ($onehot0({!ram_ctl.buffer_write_strobe_n,
    ram_ctl.ram_output_enable, ram_ctl.id_prom_output_enable})) else $error("two device enables");
  chk_access_follows: assert property ($fell(ram_ctl.ctrl_ready) |-> ##16
    (ram_ctl.host_bufs_enable && !ram_ctl.ctrl_ready) ##16 ram_ctl.ctrl_bufs_enable)
    else $error("setup not followed by access and release");
  chk_release_idle: assert property ($rose(ram_ctl.ctrl_bufs_enable) |->
    !ram_ctl.ctrl_ready && ram_ctl.buffer_write_strobe_n ##16 ram_ctl.ctrl_ready)
    else $error("release did not return to idle");
  chk_ready_len: assert property ($rose(ram_ctl.ctrl_ready) |-> low_cnt_reg == LOW_CYCLES)
    else $error("ready low length wrong");
  chk_wait_bound: assert property (low_cnt_reg <= LOW_CYCLES)
    else $error("ready held low too long");
  // a state change lands five clk after the bus clock pin falls, one after the filtered fall, well inside the low half period
  chk_fall_step: assert property ($changed(ram_ctl.host_bufs_enable) |-> !host_pins.bus_clock)
    else $error("state stepped off the bus clock fall");
  chk_hard_idle: assert property (disable iff (srst) $fell(hard_reset_n) |-> ##[1:8]
    (ram_ctl.ctrl_ready && ram_ctl.ctrl_bufs_enable)) else $error("hard reset did not idle");
  chk_grant_follows: assert property ($rose(ctrl_bus_request) |-> ##[1:6] bus_grab_grant)
    else $error("grant did not follow request");
  chk_irq_cause: assert property ($rose(card_level_irq) |-> irq_hist_reg != 8'h00)
    else $error("irq set without cause");
  chk_irq_holds: assert property ($fell(card_level_irq) |-> clr_age_reg < 8'h28)
    else $error("irq dropped without clear");
  cover property (!ram_ctl.buffer_write_strobe_n);
  cover property (ram_ctl.id_prom_output_enable);
  cover property ($rose(card_level_irq));
endmodule
bind dprcs_cycle_stealer dprcs_cycle_stealer_properties #(.STEAL_CNT_W(STEAL_CNT_W)) u_props (
  .clk(clk), .srst(srst), .hard_reset_n(hard_reset_n), .host_pins(host_pins),
  .ctrl_bus_request(ctrl_bus_request), .ctrl_irq(ctrl_irq), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .ram_ctl(ram_ctl), .page_select(page_select), .controller_reset_bit(controller_reset_bit),
  .loopback_bit(loopback_bit), .chan_attn_bit(chan_attn_bit), .bus_grab_grant(bus_grab_grant),
  .card_level_irq(card_level_irq));
`default_nettype wire

//--- dv/dprcs_host_model.sv
// Purpose: host processor on the expansion bus
// Assumes: bus clock derived from clk, half period HALF cycles
// Notes: released data lines show the inverse of the last byte
`default_nettype none
module dprcs_host_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  output var dprcs_pkg::dprcs_host_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial
  begin
    pins = '0;
    pins.target = dprcs_pkg::DPRCS_TGT_NONE;
  end
  always @(posedge clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      pins.bus_clock <= !pins.bus_clock;
  end
  task automatic cycle(input logic rnw, input dprcs_pkg::dprcs_target_t tgt, input logic [7:0] data);
    int periods;
    periods = (tgt == dprcs_pkg::DPRCS_TGT_PROM) ? 6 : 5;
    @(negedge pins.bus_clock);
    @(posedge clk);
    pins.podule_select <= 1'b1;
    pins.read_not_write <= rnw;
    pins.target <= tgt;
    pins.wdata <= data;
    repeat (periods * 2 * HALF) @(posedge clk);
    pins.podule_select <= 1'b0;
    pins.target <= dprcs_pkg::DPRCS_TGT_NONE;
    pins.wdata <= ~data;
    repeat (2 * HALF) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- dv/dprcs_cycle_stealer_test.sv
// Purpose: self-checking bench for the cycle stealer
// Assumes: 16 clk per bus period, so a steal holds ready low 48 clk
// Notes: registers reached over APB and by host register cycles
`default_nettype none
module dprcs_cycle_stealer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hard_reset_n = 1'b1;
  logic ctrl_bus_request = 1'b0;
  logic ctrl_irq = 1'b0;
  dprcs_pkg::dprcs_apb_req_t apb_req = '0;
  dprcs_pkg::dprcs_apb_rsp_t apb_rsp;
  dprcs_pkg::dprcs_ram_ctl_t ram_ctl;
  dprcs_pkg::dprcs_host_pins_t host_pins;
  logic [3:0] page_select;
  logic controller_reset_bit, loopback_bit, chan_attn_bit, bus_grab_grant, card_level_irq;
  int fail_count = 0, checks_done = 0, n_low = 0, n_w = 0, n_r = 0, n_p = 0;
  dprcs_host_model #(.HALF(8)) i_dprcs_host_model (.clk(clk), .pins(host_pins));
  dprcs_cycle_stealer i_dprcs_cycle_stealer (.clk(clk), .srst(srst), .hard_reset_n(hard_reset_n),
    .host_pins(host_pins), .ctrl_bus_request(ctrl_bus_request), .ctrl_irq(ctrl_irq),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .ram_ctl(ram_ctl), .page_select(page_select),
    .controller_reset_bit(controller_reset_bit), .loopback_bit(loopback_bit),
    .chan_attn_bit(chan_attn_bit), .bus_grab_grant(bus_grab_grant), .card_level_irq(card_level_irq));
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    n_low += (ram_ctl.ctrl_ready === 1'b0);
    n_w += (ram_ctl.buffer_write_strobe_n === 1'b0);
    n_r += (ram_ctl.ram_output_enable === 1'b1);
    n_p += (ram_ctl.id_prom_output_enable === 1'b1);
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clk);
    end
    while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic steal(input logic rnw, input dprcs_pkg::dprcs_target_t tgt, input logic [7:0] d,
    input int ew, input int er, input int ep);
    int l0, w0, r0, p0;
    l0 = n_low;
    w0 = n_w;
    r0 = n_r;
    p0 = n_p;
    i_dprcs_host_model.cycle(rnw, tgt, d);
    check("ready low cycles", n_low - l0, 48);
    check("write strobe cycles", n_w - w0, ew);
    check("ram enable cycles", n_r - r0, er);
    check("prom enable cycles", n_p - p0, ep);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial
  begin
    logic [31:0] q;
    logic e;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    check("idle ram controls", {26'h0, ram_ctl}, 32'h19);
    check("reset bits", {24'h0, page_select, controller_reset_bit, loopback_bit, chan_attn_bit, card_level_irq}, 32'h08);
    apb(1'b0, dprcs_pkg::CTRL_OFFSET, 32'h0, q, e);
    check("control word", q, 32'h10);
    apb(1'b1, dprcs_pkg::CTRL_OFFSET, 32'h2A, q, e);
    apb(1'b0, dprcs_pkg::CTRL_OFFSET, 32'h0, q, e);
    check("control readback", q, 32'h2A);
    check("page select", {28'h0, page_select}, 32'hA);
    apb(1'b0, 12'h100, 32'h0, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    $display("test registers done");
    steal(1'b0, dprcs_pkg::DPRCS_TGT_RAM, 8'h00, 16, 0, 0);
    steal(1'b1, dprcs_pkg::DPRCS_TGT_RAM, 8'h00, 0, 16, 0);
    ctrl_bus_request <= 1'b1;
    steal(1'b1, dprcs_pkg::DPRCS_TGT_PROM, 8'h00, 0, 0, 16);
    steal(1'b0, dprcs_pkg::DPRCS_TGT_REGS, 8'h05, 0, 0, 0);
    check("host register write", {24'h0, page_select, controller_reset_bit, loopback_bit, chan_attn_bit, card_level_irq}, 32'h50);
    check("grant high", {31'h0, bus_grab_grant}, 32'h1);
    ctrl_bus_request <= 1'b0;
    repeat (8) @(posedge clk);
    check("grant low", {31'h0, bus_grab_grant}, 32'h0);
    $display("test steals done");
    // hard reset lands in the setup period, so it must cut a busy steal short
    fork
      i_dprcs_host_model.cycle(1'b1, dprcs_pkg::DPRCS_TGT_RAM, 8'h00);
      begin
        wait (ram_ctl.ctrl_ready === 1'b0);
        @(posedge clk);
        check("steal under way", {31'h0, ram_ctl.host_bufs_enable}, 32'h1);
        hard_reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        check("hard reset idle", {26'h0, ram_ctl}, 32'h19);
        check("hard reset keeps page", {28'h0, page_select}, 32'h5);
        hard_reset_n <= 1'b1;
      end
    join
    apb(1'b0, dprcs_pkg::STEAL_CNT_OFFSET, 32'h0, q, e);
    check("steal count", q, 32'h4);
    $display("test hard reset done");
    ctrl_irq <= 1'b1;
    repeat (4) @(posedge clk);
    ctrl_irq <= 1'b0;
    repeat (8) @(posedge clk);
    check("irq latched", {31'h0, card_level_irq}, 32'h1);
    apb(1'b0, dprcs_pkg::STATUS_OFFSET, 32'h0, q, e);
    check("status irq flag", {31'h0, q[dprcs_pkg::ST_IRQ_POS]}, 32'h1);
    apb(1'b1, dprcs_pkg::CTRL_OFFSET, 32'hC5, q, e);
    repeat (4) @(posedge clk);
    check("irq cleared", {31'h0, card_level_irq}, 32'h0);
    check("channel attention", {31'h0, chan_attn_bit}, 32'h1);
    apb(1'b0, dprcs_pkg::CTRL_OFFSET, 32'h0, q, e);
    check("clear bit reads zero", q, 32'h85);
    $display("test interrupt done");
    complete_run();
  end
endmodule
`default_nettype wire
